// *** logic/cssq_pkg.sv ***
// Constants, register map and state codes for the calibration and setup sequencer
package cssq_pkg;
  // Clock rate and time base
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  // Times counted in milliseconds
  localparam logic [14:0] MEAS_MS = 15'h3E80;
  localparam logic [14:0] IDLE_MS = 15'h7530;
  localparam logic [9:0] SEC_MS = 10'h3E8;
  localparam logic [9:0] FLASH_MS = 10'h1F4;
  // Register byte offsets
  localparam logic [7:0] OFS_SCALE = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_CALCODE = 8'h08;
  localparam logic [7:0] OFS_ENGCODE = 8'h0C;
  localparam logic [7:0] OFS_FACCODE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CALSPD = 8'h18;
  localparam logic [7:0] OFS_DISPLAY = 8'h1C;
  // Setup parameter defaults and ranges; scale in 1/1200ths (divided by SCALE_DIV)
  localparam logic [13:0] SCALE_DEF = 14'h04B0;
  localparam logic [13:0] SCALE_MIN = 14'h0001;
  localparam logic [13:0] SCALE_MAX = 14'h270F;
  localparam logic [29:0] SCALE_DIV = 30'h000004B0;
  localparam logic [29:0] DISP_MAX = 30'h0000270F;
  localparam logic [5:0] DELAY_DEF = 6'h0A;
  localparam logic [5:0] DELAY_MIN = 6'h01;
  localparam logic [5:0] ENG_DELAY_MAX = 6'h1E;
  localparam logic [5:0] FAC_DELAY_MAX = 6'h3C;
  localparam logic [13:0] ENG_SCALE_STEP = 14'h000A;
  localparam logic [13:0] FAC_SCALE_STEP = 14'h0001;
  // Codes: two bits per symbol, first symbol lowest; A=1, B=2, C=3
  localparam logic [7:0] CAL_CODE_DEF = 8'h39;
  localparam logic [7:0] ENG_CODE_DEF = 8'hAA;
  localparam logic [7:0] FAC_CODE_DEF = 8'h6D;
  localparam logic [2:0] CAL_CODE_LEN = 3'h3;
  localparam logic [2:0] ENG_CODE_LEN = 3'h4;
  localparam logic [2:0] FAC_CODE_LEN = 3'h4;
  // Menu items
  localparam logic [1:0] ITEM_CAL = 2'h0;
  localparam logic [1:0] ITEM_SETUP = 2'h1;
  localparam logic [1:0] ITEM_TEST = 2'h2;
  // Parameter walk: scale, start-up delay, engineer code (factory only)
  localparam logic [1:0] PAR_SCALE = 2'h0;
  localparam logic [1:0] PAR_DELAY = 2'h1;
  localparam logic [1:0] PAR_ENGCODE = 2'h2;

  typedef enum logic [9:0] {
    ST_STATUS = 10'h001,
    ST_MENU = 10'h002,
    ST_CODE = 10'h004,
    ST_WAIT_RUN = 10'h008,
    ST_STARTUP = 10'h010,
    ST_MEASURE = 10'h020,
    ST_SETUP_SEL = 10'h040,
    ST_PARAM = 10'h080,
    ST_SAVE = 10'h100,
    ST_FAC_SHOW = 10'h200
  } cssq_state_t;

  typedef enum logic [1:0] {
    TGT_CAL = 2'h0,
    TGT_ENG = 2'h1,
    TGT_FAC = 2'h2
  } cssq_target_t;

  // Message shown on the text display
  localparam logic [3:0] MSG_READY = 4'h0;
  localparam logic [3:0] MSG_NOT_CAL = 4'h1;
  localparam logic [3:0] MSG_MENU = 4'h2;
  localparam logic [3:0] MSG_CODE = 4'h3;
  localparam logic [3:0] MSG_START_ELEV = 4'h4;
  localparam logic [3:0] MSG_STARTUP = 4'h5;
  localparam logic [3:0] MSG_PROGRESS = 4'h6;
  localparam logic [3:0] MSG_SETUP = 4'h7;
  localparam logic [3:0] MSG_PARAM = 4'h8;
  localparam logic [3:0] MSG_SAVE = 4'h9;
  localparam logic [3:0] MSG_FAC_NUM = 4'hA;
endpackage

// *** logic/cssq_top.sv ***
// Calibration, menu and setup sequencer with display scaling and APB registers
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module cssq_top #(
  parameter int unsigned TICK_CYCLES = cssq_pkg::TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_a,
  input wire logic btn_b,
  input wire logic btn_c,
  input wire logic interlock,
  input wire logic probe_pulse,
  input wire logic elevator_fault,
  input wire logic alarm_cond,
  input wire logic stop_cond,
  output logic alarm_relay,
  output logic stop_relay,
  output logic alarm_lamp,
  output logic stop_lamp,
  output logic [3:0] msg_code,
  output logic [13:0] msg_value,
  output logic [13:0] disp_value,
  output logic disp_overrange
);
  import cssq_pkg::*;

  function automatic logic [1:0] code_sym(input logic [7:0] code, input logic [2:0] idx);
    code_sym = code[{idx[1:0], 1'b0} +: 2];
  endfunction

  // Symbol of a touch during code entry: A wins over B, B over C
  function automatic logic [1:0] touch_sym(input logic a, input logic b);
    touch_sym = a ? 2'h1 : (b ? 2'h2 : 2'h3);
  endfunction

  cssq_state_t state_r;
  cssq_target_t tgt_r;
  logic [17:0] tick_cnt_r;
  logic ms_tick;
  logic [9:0] sec_ms_r;
  logic sec_tick;
  logic [9:0] flash_ms_r;
  logic flash_r;
  logic a_d_r, b_d_r, c_d_r, probe_d_r;
  logic a_edge, b_edge, c_edge, any_edge, probe_edge;
  logic [14:0] idle_ms_r;
  logic [14:0] meas_ms_r;
  logic [9:0] sec_pulses_r;
  logic [15:0] ppm_r;
  logic [15:0] cal_sum_r;
  logic [15:0] cal_speed_r;
  logic calibrated_r;
  logic [5:0] delay_left_r;
  logic [1:0] cursor_r;
  logic [2:0] sym_idx_r;
  logic [2:0] code_len;
  logic [7:0] code_exp;
  logic fac_ok_r;
  logic [13:0] fac_num_r;
  logic [13:0] lfsr_r;
  logic [1:0] par_r;
  logic [13:0] wk_scale_r;
  logic [5:0] wk_delay_r;
  logic [7:0] wk_eng_r;
  logic [1:0] wk_sym;
  logic save_yes_r;
  logic [13:0] scale_r;
  logic [5:0] delay_r;
  logic [7:0] cal_code_r, eng_code_r, fac_code_r;
  logic commit;
  logic cal_done;
  logic in_cal;
  logic cal_abort;
  logic [29:0] disp_full;
  logic [13:0] scale_step;
  logic [5:0] delay_max;
  logic [1:0] par_last;
  logic apb_wr;
  logic addr_ok;

  // Millisecond time base keeps the long counters narrow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == 18'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 18'h00001;
    end
  end
  assign ms_tick = (tick_cnt_r == 18'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_ms_r <= '0;
      flash_ms_r <= '0;
      flash_r <= 1'b0;
    end else if (ms_tick) begin
      sec_ms_r <= (sec_ms_r == SEC_MS - 10'h001) ? 10'h000 : sec_ms_r + 10'h001;
      if (flash_ms_r == FLASH_MS - 10'h001) begin
        flash_ms_r <= '0;
        flash_r <= ~flash_r;
      end else begin
        flash_ms_r <= flash_ms_r + 10'h001;
      end
    end
  end
  assign sec_tick = ms_tick && (sec_ms_r == SEC_MS - 10'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
      c_d_r <= 1'b0;
      probe_d_r <= 1'b0;
    end else begin
      a_d_r <= btn_a;
      b_d_r <= btn_b;
      c_d_r <= btn_c;
      probe_d_r <= probe_pulse;
    end
  end
  assign a_edge = btn_a && !a_d_r;
  assign b_edge = btn_b && !b_d_r;
  assign c_edge = btn_c && !c_d_r;
  assign any_edge = a_edge || b_edge || c_edge;
  assign probe_edge = probe_pulse && !probe_d_r;

  // Speed measurement runs only with the interlock present
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_pulses_r <= '0;
      ppm_r <= '0;
    end else if (!interlock) begin
      sec_pulses_r <= '0;
      ppm_r <= '0;
    end else if (sec_tick) begin
      sec_pulses_r <= {9'h000, probe_edge};
      ppm_r <= 16'(sec_pulses_r) * 16'h003C;
    end else if (probe_edge) begin
      sec_pulses_r <= sec_pulses_r + 10'h001;
    end
  end

  assign in_cal = (state_r == ST_STARTUP) || (state_r == ST_MEASURE);
  assign cal_abort = in_cal && (!interlock || elevator_fault ||
                     (state_r == ST_MEASURE && sec_tick && sec_pulses_r == 10'h000));
  assign cal_done = (state_r == ST_MEASURE) && ms_tick && (meas_ms_r == MEAS_MS - 15'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_ms_r <= '0;
      cal_sum_r <= '0;
    end else if (state_r != ST_MEASURE) begin
      meas_ms_r <= '0;
      cal_sum_r <= '0;
    end else begin
      if (ms_tick) begin
        meas_ms_r <= meas_ms_r + 15'h0001;
      end
      if (probe_edge) begin
        cal_sum_r <= cal_sum_r + 16'h0001;
      end
    end
  end

  // Pulses in 16 s times 60/16 gives the average per minute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_speed_r <= '0;
      calibrated_r <= 1'b0;
    end else if (cal_done) begin
      cal_speed_r <= 16'((20'(cal_sum_r) * 20'h0000F) >> 2);
      calibrated_r <= 1'b1;
    end
  end

  assign code_len = (tgt_r == TGT_CAL) ? CAL_CODE_LEN :
                    (tgt_r == TGT_ENG) ? ENG_CODE_LEN : FAC_CODE_LEN;
  assign code_exp = (tgt_r == TGT_CAL) ? cal_code_r :
                    (tgt_r == TGT_ENG) ? eng_code_r : fac_code_r;
  assign scale_step = (tgt_r == TGT_FAC) ? FAC_SCALE_STEP : ENG_SCALE_STEP;
  assign delay_max = (tgt_r == TGT_FAC) ? FAC_DELAY_MAX : ENG_DELAY_MAX;
  assign par_last = (tgt_r == TGT_FAC) ? PAR_ENGCODE : PAR_DELAY;
  assign wk_sym = code_sym(wk_eng_r, sym_idx_r);
  assign commit = (state_r == ST_SAVE) && c_edge && save_yes_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 14'h0001;
    end else begin
      lfsr_r <= {lfsr_r[12:0], lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[11] ^ lfsr_r[1]};
    end
  end

  // Idle timer restarts on every touch while a menu is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_ms_r <= '0;
    end else if (any_edge || state_r == ST_STATUS || in_cal) begin
      idle_ms_r <= '0;
    end else if (ms_tick) begin
      idle_ms_r <= idle_ms_r + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_STATUS;
      tgt_r <= TGT_CAL;
      cursor_r <= ITEM_CAL;
      sym_idx_r <= '0;
      delay_left_r <= '0;
      par_r <= PAR_SCALE;
      save_yes_r <= 1'b0;
      fac_num_r <= '0;
      wk_scale_r <= SCALE_DEF;
      wk_delay_r <= DELAY_DEF;
      wk_eng_r <= ENG_CODE_DEF;
    end else if (cal_abort) begin
      state_r <= ST_STATUS;
    end else if (idle_ms_r == IDLE_MS - 15'h0001 && ms_tick && !in_cal &&
                 state_r != ST_WAIT_RUN) begin
      state_r <= ST_STATUS;
    end else begin
      case (state_r)
        ST_STATUS: begin
          if (c_edge) begin
            state_r <= ST_MENU;
            cursor_r <= ITEM_CAL;
          end
        end
        ST_MENU: begin
          if (a_edge) begin
            state_r <= ST_STATUS;
          end else if (b_edge) begin
            cursor_r <= (cursor_r == ITEM_TEST) ? ITEM_CAL : cursor_r + 2'h1;
          end else if (c_edge) begin
            sym_idx_r <= '0;
            if (cursor_r == ITEM_CAL) begin
              tgt_r <= TGT_CAL;
              state_r <= ST_CODE;
            end else if (cursor_r == ITEM_SETUP) begin
              state_r <= ST_SETUP_SEL;
              cursor_r <= 2'h0;
            end else begin
              state_r <= ST_STATUS;
            end
          end
        end
        ST_SETUP_SEL: begin
          if (a_edge || b_edge) begin
            cursor_r <= {1'b0, ~cursor_r[0]};
          end else if (c_edge) begin
            sym_idx_r <= '0;
            wk_scale_r <= scale_r;
            wk_delay_r <= delay_r;
            wk_eng_r <= eng_code_r;
            if (cursor_r[0]) begin
              tgt_r <= TGT_FAC;
              fac_num_r <= lfsr_r;
              state_r <= fac_ok_r ? ST_PARAM : ST_FAC_SHOW;
              par_r <= PAR_SCALE;
            end else begin
              tgt_r <= TGT_ENG;
              state_r <= ST_CODE;
            end
          end
        end
        ST_FAC_SHOW: begin
          if (c_edge) begin
            state_r <= ST_CODE;
          end
        end
        ST_CODE: begin
          if (any_edge) begin
            if (touch_sym(a_edge, b_edge) != code_sym(code_exp, sym_idx_r)) begin
              state_r <= ST_MENU;
              cursor_r <= ITEM_CAL;
            end else if (sym_idx_r == code_len - 3'h1) begin
              par_r <= PAR_SCALE;
              state_r <= (tgt_r == TGT_CAL) ? ST_WAIT_RUN : ST_PARAM;
            end else begin
              sym_idx_r <= sym_idx_r + 3'h1;
            end
          end
        end
        ST_WAIT_RUN: begin
          if (interlock) begin
            state_r <= ST_STARTUP;
            delay_left_r <= delay_r;
          end else if (a_edge) begin
            state_r <= ST_STATUS;
          end
        end
        ST_STARTUP: begin
          if (sec_tick) begin
            if (delay_left_r <= 6'h01) begin
              state_r <= ST_MEASURE;
            end
            delay_left_r <= delay_left_r - 6'h01;
          end
        end
        ST_MEASURE: begin
          if (cal_done) begin
            state_r <= ST_STATUS;
          end
        end
        ST_PARAM: begin
          if (a_edge || b_edge) begin
            case (par_r)
              PAR_SCALE: begin
                if (b_edge) begin
                  wk_scale_r <= (wk_scale_r > SCALE_MAX - scale_step) ? SCALE_MAX :
                                wk_scale_r + scale_step;
                end else begin
                  wk_scale_r <= (wk_scale_r < SCALE_MIN + scale_step) ? SCALE_MIN :
                                wk_scale_r - scale_step;
                end
              end
              PAR_DELAY: begin
                if (b_edge && wk_delay_r < delay_max) begin
                  wk_delay_r <= wk_delay_r + 6'h01;
                end else if (a_edge && wk_delay_r > DELAY_MIN) begin
                  wk_delay_r <= wk_delay_r - 6'h01;
                end
              end
              default: begin
                wk_eng_r[{sym_idx_r[1:0], 1'b0} +: 2] <=
                  (wk_sym == 2'h3) ? 2'h1 : wk_sym + 2'h1;
              end
            endcase
          end else if (c_edge) begin
            if (par_r == PAR_ENGCODE && sym_idx_r != ENG_CODE_LEN - 3'h1) begin
              sym_idx_r <= sym_idx_r + 3'h1;
            end else if (par_r == par_last) begin
              state_r <= ST_SAVE;
              save_yes_r <= 1'b0;
            end else begin
              par_r <= par_r + 2'h1;
              sym_idx_r <= '0;
            end
          end
        end
        ST_SAVE: begin
          if (a_edge || b_edge) begin
            save_yes_r <= ~save_yes_r;
          end else if (c_edge) begin
            state_r <= ST_STATUS;
          end
        end
        default: begin
          state_r <= ST_STATUS;
        end
      endcase
    end
  end

  // Factory code stays valid until a factory setup save is confirmed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fac_ok_r <= 1'b0;
    end else if (commit && tgt_r == TGT_FAC) begin
      fac_ok_r <= 1'b0;
    end else if (state_r == ST_CODE && tgt_r == TGT_FAC && any_edge &&
                 sym_idx_r == FAC_CODE_LEN - 3'h1 &&
                 touch_sym(a_edge, b_edge) == code_sym(fac_code_r, sym_idx_r)) begin
      fac_ok_r <= 1'b1;
    end
  end

  // Stored setup; reset values stand for the factory defaults
  assign apb_wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_r <= SCALE_DEF;
      delay_r <= DELAY_DEF;
      cal_code_r <= CAL_CODE_DEF;
      eng_code_r <= ENG_CODE_DEF;
      fac_code_r <= FAC_CODE_DEF;
    end else if (commit) begin
      scale_r <= wk_scale_r;
      delay_r <= wk_delay_r;
      eng_code_r <= wk_eng_r;
    end else if (apb_wr) begin
      case (paddr)
        OFS_SCALE: begin
          if (pwdata[13:0] >= SCALE_MIN && pwdata[13:0] <= SCALE_MAX) begin
            scale_r <= pwdata[13:0];
          end
        end
        OFS_DELAY: begin
          if (pwdata[5:0] >= DELAY_MIN && pwdata[5:0] <= FAC_DELAY_MAX) begin
            delay_r <= pwdata[5:0];
          end
        end
        OFS_CALCODE: cal_code_r <= pwdata[7:0];
        OFS_ENGCODE: eng_code_r <= pwdata[7:0];
        OFS_FACCODE: fac_code_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Scaling touches only the shown number, never the trip reference
  assign disp_full = (30'(ppm_r) * 30'(scale_r)) / SCALE_DIV;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_value <= '0;
      disp_overrange <= 1'b0;
    end else begin
      disp_overrange <= (disp_full > DISP_MAX);
      disp_value <= (disp_full > DISP_MAX) ? 14'h0000 : disp_full[13:0];
    end
  end

  // Relays follow the interlock; uncalibrated unit pulses the alarm relay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_relay <= 1'b0;
      stop_relay <= 1'b0;
      alarm_lamp <= 1'b0;
      stop_lamp <= 1'b0;
    end else if (in_cal && interlock) begin
      alarm_relay <= 1'b1;
      stop_relay <= 1'b1;
      alarm_lamp <= (state_r == ST_STARTUP) ? flash_r : 1'b0;
      stop_lamp <= 1'b0;
    end else if (!calibrated_r) begin
      alarm_relay <= interlock && flash_r;
      stop_relay <= 1'b0;
      alarm_lamp <= flash_r;
      stop_lamp <= 1'b0;
    end else begin
      alarm_relay <= interlock && !alarm_cond;
      stop_relay <= interlock && !stop_cond;
      alarm_lamp <= alarm_cond;
      stop_lamp <= stop_cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_code <= MSG_NOT_CAL;
      msg_value <= '0;
    end else begin
      msg_value <= '0;
      case (state_r)
        ST_STATUS: msg_code <= calibrated_r ? MSG_READY : MSG_NOT_CAL;
        ST_MENU: begin
          msg_code <= MSG_MENU;
          msg_value <= {12'h000, cursor_r};
        end
        ST_CODE: begin
          msg_code <= MSG_CODE;
          msg_value <= {11'h000, sym_idx_r};
        end
        ST_WAIT_RUN: msg_code <= MSG_START_ELEV;
        ST_STARTUP: begin
          msg_code <= MSG_STARTUP;
          msg_value <= {8'h00, delay_left_r};
        end
        ST_MEASURE: begin
          msg_code <= MSG_PROGRESS;
          msg_value <= 14'((22'(meas_ms_r) * 22'h000064) / 22'(MEAS_MS));
        end
        ST_SETUP_SEL: begin
          msg_code <= MSG_SETUP;
          msg_value <= {12'h000, cursor_r};
        end
        ST_FAC_SHOW: begin
          msg_code <= MSG_FAC_NUM;
          msg_value <= fac_num_r;
        end
        ST_PARAM: begin
          msg_code <= MSG_PARAM;
          msg_value <= (par_r == PAR_SCALE) ? wk_scale_r :
                       (par_r == PAR_DELAY) ? {8'h00, wk_delay_r} : {6'h00, wk_eng_r};
        end
        ST_SAVE: begin
          msg_code <= MSG_SAVE;
          msg_value <= {13'h0000, save_yes_r};
        end
        default: msg_code <= MSG_READY;
      endcase
    end
  end

  // Zero-wait APB slave; unmapped addresses answer with an error
  assign addr_ok = (paddr <= OFS_DISPLAY) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // Read data is latched in the setup phase, so the access phase sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_SCALE: prdata <= {18'h00000, scale_r};
        OFS_DELAY: prdata <= {26'h0000000, delay_r};
        OFS_CALCODE: prdata <= {24'h000000, cal_code_r};
        OFS_ENGCODE: prdata <= {24'h000000, eng_code_r};
        OFS_FACCODE: prdata <= {24'h000000, fac_code_r};
        OFS_STATUS: prdata <= {19'h00000, fac_ok_r, interlock, calibrated_r, state_r};
        OFS_CALSPD: prdata <= {16'h0000, cal_speed_r};
        OFS_DISPLAY: prdata <= {1'b0, disp_overrange, disp_value, ppm_r};
        default: prdata <= '0;
      endcase
    end
  end
endmodule

// *** tb/cssq_operator.sv ***
// Starter interlock and motion probe of a running elevator
`timescale 1ns/10ps
module cssq_operator (
  input wire logic pclk,
  input wire logic run,
  output logic interlock,
  output logic probe_pulse
);
  int cnt = 0;
  // Starter feeds the interlock only while the motor runs
  assign interlock = run;
  always @(posedge pclk) begin
    cnt <= run ? (cnt + 1) % 40 : 0;
    probe_pulse <= run && cnt < 20;
  end
endmodule

// *** tb/cssq_top_monitor.sv ***
// Pin-level checks of the sequencer
`timescale 1ns/10ps
module cssq_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic btn_a,
  input wire logic btn_b,
  input wire logic btn_c,
  input wire logic interlock,
  input wire logic alarm_cond,
  input wire logic stop_cond,
  input wire logic alarm_relay,
  input wire logic stop_relay,
  input wire logic alarm_lamp,
  input wire logic [3:0] msg_code,
  input wire logic [13:0] msg_value,
  input wire logic [13:0] disp_value,
  input wire logic disp_overrange
);
  import cssq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire idle_st = msg_code == MSG_READY || msg_code == MSG_NOT_CAL;
  AST_MENU_OPEN: assert property (idle_st && $rose(btn_c) && !btn_a && !btn_b
    |-> ##2 msg_code == MSG_MENU) else $error("menu did not open");
  AST_RED_DISMISS: assert property (msg_code == MSG_MENU && $rose(btn_a) && !btn_c
    |-> ##2 idle_st) else $error("menu not dismissed");
  // Five cycles leave room for an input synchroniser
  AST_NO_INTERLOCK: assert property (!interlock [*5]
    |-> !stop_relay && !alarm_relay) else $error("relay on without interlock");
  AST_NOCAL_STOP: assert property (msg_code == MSG_NOT_CAL [*2] |-> !stop_relay)
    else $error("stop relay on while uncalibrated");
  AST_START_RELAYS: assert property ((msg_code == MSG_STARTUP && interlock) [*4]
    |-> alarm_relay && stop_relay) else $error("relays off in start-up");
  AST_MEAS_LAMP: assert property ((msg_code == MSG_PROGRESS && interlock &&
    !alarm_cond) [*2] |-> !alarm_lamp) else $error("lamp lit while measuring");
  AST_PCT_MAX: assert property (msg_code == MSG_PROGRESS |-> msg_value <= 14'h0064)
    else $error("progress above 100");
  AST_OVR_ZERO: assert property (disp_value <= 14'h270F &&
    (!disp_overrange || disp_value == 14'h0000))
    else $error("display beyond four digits");
  AST_RUN_STOP: assert property ((msg_code == MSG_READY && interlock && !stop_cond) [*4]
    |-> stop_relay) else $error("stop relay off in normal run");
endmodule

// *** tb/test_cssq_top.sv ***
// Self-checking bench for the sequencer
`timescale 1ns/10ps
module test_cssq_top;
  import cssq_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 0, prdata, rd, csp;
  logic pready, pslverr, err, btn_a = 0, btn_b = 0, btn_c = 0, elevator_fault = 0;
  logic alarm_cond = 0, stop_cond = 0, interlock, probe_pulse, alarm_relay, stop_relay;
  logic alarm_lamp, stop_lamp, disp_overrange;
  logic [3:0] msg_code;
  logic [13:0] msg_value, disp_value;
  int error_cnt = 0, n_compared = 0;
  always #2 pclk = ~pclk;
  cssq_top #(.TICK_CYCLES(2)) dut (.*);
  cssq_operator op (.*);
  task automatic close_out;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (n == 50) chk("pready", 0, 1);
    if (n == 50) close_out;
  endtask
  task automatic wait_msg(input logic [3:0] c, input int lim);
    int n;
    for (n = 0; n < lim && msg_code !== c; n++) @(posedge pclk);
    chk("msg_code", msg_code, c);
    if (n == lim) close_out;
  endtask
  task automatic keys(input string s);
    foreach (s[i]) begin
      @(posedge pclk);
      {btn_a, btn_b, btn_c} <= 3'b100 >> (s[i] - "A");
      @(posedge pclk);
      {btn_a, btn_b, btn_c} <= 3'b000;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic cal_go;
    keys("CCABC");
    wait_msg(MSG_START_ELEV, 10);
    run <= 1;
    wait_msg(MSG_STARTUP, 10);
    chk("msg_value", msg_value, 1);
  endtask
  task automatic t_reset;
    chk("msg_code", msg_code, MSG_NOT_CAL);
    apb(0, OFS_SCALE, 0);
    chk("scale", rd, 32'h000004B0);
    apb(1, OFS_SCALE, 32'h00002710);
    apb(0, OFS_SCALE, 0);
    chk("scale", rd, 32'h000004B0);
    apb(0, 8'h20, 0);
    chk("pslverr", err, 1);
    apb(1, OFS_DELAY, 32'h00000001);
  endtask
  task automatic t_menu;
    keys("CBBBC");
    chk("msg_code", msg_code, MSG_CODE);
    keys("B");
    chk("msg_code", msg_code, MSG_MENU);
    keys("A");
    chk("msg_code", msg_code, MSG_NOT_CAL);
  endtask
  task automatic t_cal;
    cal_go();
    repeat (6) @(posedge pclk);
    chk("relays", {alarm_relay, stop_relay}, 2'b11);
    run <= 0;
    wait_msg(MSG_NOT_CAL, 10);
    repeat (6) @(posedge pclk);
    chk("relays", {alarm_relay, stop_relay}, 2'b00);
    cal_go();
    wait_msg(MSG_PROGRESS, 3000);
    elevator_fault <= 1;
    wait_msg(MSG_NOT_CAL, 10);
    elevator_fault <= 0;
    run <= 0;
    cal_go();
    wait_msg(MSG_PROGRESS, 3000);
    chk("alarm_lamp", alarm_lamp, 0);
    wait_msg(MSG_READY, 33000);
    apb(0, OFS_STATUS, 0);
    chk("calibrated", rd[10], 1);
    apb(0, OFS_CALSPD, 0);
    csp = rd;
  endtask
  task automatic t_disp;
    repeat (2100) @(posedge pclk);
    chk("disp_value", disp_value, 14'h0BB8);
    apb(1, OFS_SCALE, 32'h00000258);
    repeat (5) @(posedge pclk);
    chk("disp_value", disp_value, 14'h05DC);
    apb(0, OFS_CALSPD, 0);
    chk("calspd", rd, csp);
    apb(1, OFS_SCALE, 32'h0000270F);
    repeat (5) @(posedge pclk);
    chk("overrange", {disp_overrange, disp_value}, 15'h4000);
    apb(1, OFS_SCALE, 32'h00000001);
    repeat (5) @(posedge pclk);
    chk("disp_value", disp_value, 14'h0002);
    {alarm_cond, stop_cond} <= 2'b11;
    repeat (3) @(posedge pclk);
    chk("trip", {alarm_relay, stop_relay, alarm_lamp, stop_lamp}, 4'b0011);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_menu();
    t_cal();
    t_disp();
    close_out();
  end
endmodule
bind cssq_top cssq_top_monitor mon (.*);
